//--- hw/bt_pkg.sv
/*
  bt_pkg: register map, field layout, reset values and timing
  constants of the basic up timer.
  Assumes a 32-bit AXI4-Lite bus with a 12-bit byte address.
*/
`default_nettype none

package bt_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // register indices; byte address is four times the index
  localparam logic [9:0] MODE_IDX = 10'h0d8;
  localparam logic [9:0] COUNT_IDX = 10'h0d9;
  localparam logic [9:0] STAT_IDX = 10'h0e0;
  localparam logic [9:0] MASK_IDX = 10'h0e1;
  localparam logic [ADDR_W-1:0] MODE_ADDR = {MODE_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] COUNT_ADDR = {COUNT_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] MASK_ADDR = {MASK_IDX, 2'b00};

  // mode register fields
  localparam int unsigned MODE_SRC_BIT = 0;
  localparam int unsigned MODE_GN_BIT = 1;
  localparam int unsigned MODE_RATE_LSB = 4;
  localparam int unsigned MODE_RATE_MSB = 6;
  localparam int unsigned MODE_RUN_BIT = 7;
  localparam logic [7:0] MODE_WMASK = 8'hf3;
  localparam logic [7:0] MODE_RST = 8'h00;

  // counter and prescaler
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] PRE_FULL = 8'hff;
  localparam int unsigned STAT_TO_BIT = 0;

  // rtc interval: 256 rtc ticks at 512 Hz give 0.5 s
  localparam int unsigned RTC_INTERVAL_MS = 500;
  localparam int unsigned RTC_TICK_HZ = 512;
  localparam int unsigned RTC_TICKS = RTC_INTERVAL_MS * RTC_TICK_HZ / 1000;

endpackage

`default_nettype wire

//--- hw/bt_timer.sv
/*
  bt_timer: 8-bit basic up timer with prescaler, rtc source,
  overflow interrupt and low-power wake pulse, AXI4-Lite slave.
  Assumes clk_sys is the cpu instruction clock (100 MHz) and
  rtc_tick is a one-cycle enable synchronous to clk_sys.
*/
//////////////////////////////////////////////////////////////////
// Summary of operation
// (RL1) 8-bit binary up counter, one step per selected tick when enabled.
// (RL2) FFH to 00H wrap keeps counting and sets the timer interrupt flag.
// (RL3) Mode bit 0: 0 prescaled cpu clock, 1 real-time clock source.
// (RL4) In rtc mode rate and preload are ignored; interval fixed 0.5 s.
// (RL5) Mode bits 6:4 pick divisor 256 (000) halving down to 2 (111).
// (RL6) Mode bit 7 gates counting; cleared, the count holds.
// (RL7) With the timer enabled, a time-out wakes the low-power wait state.
// (RL8) Count register, index D9H, 8-bit read/write live count, reset zero.
// (RL9) Preload 256 minus interval ticks; overflow after that many ticks.
// (RL10) Mode bit 1 is a read/write wake enable exported to the event timer.
// (RL11) Software clears enable, irq enable, flag, then sets up and enables.
// (RL12) Flag set on overflow, held until cleared; irq needs flag and enable.
// (RL13) Rtc and prescaled ticks are one-cycle enables; count only on them.
//////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none

module bt_timer
  import bt_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // rtc source
  input wire logic rtc_tick,
  // write address channel
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // events and controls
  output logic irq,
  output logic wake,
  output logic event_timer_wake_en
);

  //////////////////////////////////////////////////////////////////
  // bus state
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic wstrb_q, wstrb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic arready_q, arready_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_go, rd_go, wr_hit, rd_hit;
  logic [7:0] rd_val;

  // timer state
  logic [7:0] mode_q, mode_d, count_q, count_d, pre_q, pre_d;
  logic flag_q, flag_d, en_q, en_d, irq_q, irq_d, wake_q, wake_d;
  logic mode_wr, count_wr, mask_wr, stat_rd;
  logic rtc_mode, run, pre_tick, tick, adv, count_ld, timeout;
  logic [2:0] sel;
  logic [7:0] pre_mask;

  // all checks run on clk_sys and are off during reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  //////////////////////////////////////////////////////////////////
  // address decode and read mux
  always_comb begin
    wr_hit = (awaddr_q == MODE_ADDR) || (awaddr_q == COUNT_ADDR) ||
             (awaddr_q == STAT_ADDR) || (awaddr_q == MASK_ADDR);
    rd_hit = 1'b1;
    case (s_axi_araddr)
      MODE_ADDR: rd_val = mode_q & MODE_WMASK;
      COUNT_ADDR: rd_val = count_q;
      STAT_ADDR: rd_val = {7'h00, flag_q};
      MASK_ADDR: rd_val = {7'h00, en_q};
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // axi4-lite handshakes: aw and w in any order, response after both
  always_comb begin
    aw_have_d = aw_have_q;
    awaddr_d = awaddr_q;
    w_have_d = w_have_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    wr_go = 1'b0;
    rd_go = 1'b0;
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata[7:0];
      wstrb_d = s_axi_wstrb[0];
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      wr_go = 1'b1;
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rd_go = 1'b1;
      rvalid_d = 1'b1;
      rdata_d = {24'h000000, rd_val};
      rresp_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  // bus registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
      w_have_q <= 1'b0;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      awaddr_q <= awaddr_d;
      w_have_q <= w_have_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // tick selection, counting and events
  always_comb begin
    mode_wr = wr_go && wstrb_q && (awaddr_q == MODE_ADDR);
    count_wr = wr_go && wstrb_q && (awaddr_q == COUNT_ADDR);
    mask_wr = wr_go && wstrb_q && (awaddr_q == MASK_ADDR);
    stat_rd = rd_go && (s_axi_araddr == STAT_ADDR);
    rtc_mode = mode_q[MODE_SRC_BIT];
    run = mode_q[MODE_RUN_BIT];
    sel = mode_q[MODE_RATE_MSB:MODE_RATE_LSB];
    pre_mask = PRE_FULL >> sel; // RL5
    pre_tick = ((pre_q & pre_mask) == pre_mask); // RL5 RL13
    tick = rtc_mode ? rtc_tick : pre_tick; // RL3 RL13
    adv = run && tick; // RL6
    count_ld = count_wr && !rtc_mode; // RL4 RL9
    timeout = adv && (count_q == COUNT_MAX) && !count_ld; // RL2
    pre_d = pre_q + 8'h01;
    count_d = count_q;
    if (count_ld) begin
      count_d = wdata_q; // RL8 RL9
    end else if (adv) begin
      count_d = count_q + 8'h01; // RL1
    end
    mode_d = mode_wr ? (wdata_q & MODE_WMASK) : mode_q; // RL10
    en_d = mask_wr ? wdata_q[STAT_TO_BIT] : en_q;
    flag_d = stat_rd ? 1'b0 : flag_q;
    if (timeout) begin
      flag_d = 1'b1; // RL12
    end
    irq_d = flag_d && en_d; // RL12
    wake_d = timeout; // RL7
  end

  // timer registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_q <= MODE_RST;
      count_q <= COUNT_RST;
      pre_q <= 8'h00;
      flag_q <= 1'b0;
      en_q <= 1'b0;
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      count_q <= count_d;
      pre_q <= pre_d;
      flag_q <= flag_d;
      en_q <= en_d;
      irq_q <= irq_d;
      wake_q <= wake_d;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign irq = irq_q;
  assign wake = wake_q;
  assign event_timer_wake_en = mode_q[MODE_GN_BIT]; // RL10

  //////////////////////////////////////////////////////////////////
  // checks
  a_count_step: assert property ( // RL1
    (adv && !count_ld) |=> count_q == $past(count_q) + 8'h01)
    else $error("count did not step on tick");

  a_wrap_irq: assert property ( // RL2
    (adv && !count_ld && count_q == COUNT_MAX) |=> (count_q == 8'h00 && flag_q))
    else $error("wrap did not clear count and set flag");

  a_rtc_source: assert property ( // RL3
    (rtc_mode && run && !rtc_tick && !count_wr) |=> $stable(count_q))
    else $error("rtc mode counted without rtc tick");

  a_rtc_noload: assert property ( // RL4
    (rtc_mode && count_wr && !adv) |=> $stable(count_q))
    else $error("preload taken in rtc mode");

  a_rate_div: assert property ( // RL5
    (!rtc_mode && pre_tick && sel == 3'h0) |-> pre_q == 8'hff)
    else $error("divide by 256 tick off phase");

  a_hold_stop: assert property ( // RL6
    (!run && !count_wr) [*2] |-> $stable(count_q))
    else $error("count moved while disabled");

  a_wake_pulse: assert property ( // RL7
    timeout |=> wake ##1 !wake)
    else $error("wake not a single pulse after time-out");

  a_count_load: assert property ( // RL8
    count_ld |=> count_q == $past(wdata_q))
    else $error("count write not stored");

  a_flag_hold: assert property ( // RL12
    (flag_q && !stat_rd) |=> flag_q)
    else $error("flag dropped without a status read");

  a_irq_level: assert property ( // RL12
    (flag_q && en_q) |-> irq)
    else $error("irq low with unmasked flag");

  a_gn_export: assert property ( // RL10
    (mode_wr && wdata_q[MODE_GN_BIT]) |=> event_timer_wake_en)
    else $error("wake enable not exported");

endmodule // bt_timer

`default_nettype wire

//--- verification/bt_timer_tb_top.sv
/*
  bt_timer_tb_top: self-checking bench for the basic up timer.
  Assumes bt_pkg and bt_timer are compiled first; 100 MHz clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none

module bt_timer_tb_top
  import bt_pkg::*;
;
  localparam int MAX_CYC = 80000;
  logic clk_sys, rst, rtc_tick, awv, wv, bready, arv, rready, awrdy, wrdy, bvalid, arrdy, rvalid;
  logic irq, wake, gn_en;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  int error_cnt = 0, check_count = 0, cyc = 0, wake_cnt = 0, n, w0;

  bt_timer u_dut (.clk_sys(clk_sys), .rst(rst), .rtc_tick(rtc_tick),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arrdy),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq), .wake(wake), .event_timer_wake_en(gn_en));

  ////////////////////////////////////////////////////////////////
  // clock, inputs at time zero, reset for 10 cycles
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {rst, rtc_tick, awv, wv, bready, arv, rready} = 7'h40;
    {awaddr, araddr, wdata, wstrb} = '0;
  end

  // hang guard and wake pulse counter
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
    if (cyc == MAX_CYC) begin
      error_cnt = error_cnt + 1;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awv <= 1; wv <= 1; bready <= 1;
    do begin
      @(posedge clk_sys);
      if (awrdy) awv <= 0;
      if (wrdy) wv <= 0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    araddr <= a; arv <= 1; rready <= 1;
    do begin
      @(posedge clk_sys);
      if (arrdy) arv <= 0;
    end while (rvalid !== 1'b1);
    rd_d = rdata; rsp = rresp;
    rready <= 0;
  endtask

  task automatic wait_wake();
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wake !== 1'b1);
  endtask

  task automatic rtc_pulses(input int k);
    repeat (k) begin
      @(posedge clk_sys) rtc_tick <= 1;
      @(posedge clk_sys) rtc_tick <= 0;
      @(posedge clk_sys);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    logic [ADDR_W-1:0] regs [4];
    regs = '{MODE_ADDR, COUNT_ADDR, STAT_ADDR, MASK_ADDR};
    foreach (regs[i]) begin
      rd(regs[i]);
      chk(rd_d, 32'h0);
    end
    wr(MODE_ADDR, 32'hff); rd(MODE_ADDR); chk(rd_d, 32'hf3);
    chk(gn_en, 1'b1);
    wr(MODE_ADDR, 32'h00); chk(gn_en, 1'b0);
    wr(12'h000, 32'h5a); chk(rsp, RESP_SLVERR);
    rd(12'h004);
    chk(rd_d, 32'h0);
    chk(rsp, RESP_SLVERR);
  endtask

  // rate code r: first time-out from preload fe, then full-wrap period for r of 2 and up
  task automatic t_rate(input int r);
    int dv;
    dv = 256 >> r;
    wr(MODE_ADDR, 32'h00); wr(COUNT_ADDR, 32'hfe);
    wr(MODE_ADDR, 32'h80 | (r << 4));
    wait_wake(); chk(n >= dv && n <= 2 * dv + 4, 1'b1);
    if (r >= 2) begin
      wait_wake(); chk(n, 256 * dv);
    end
  endtask

  task automatic t_hold();
    wr(MODE_ADDR, 32'h70); wr(COUNT_ADDR, 32'h55); w0 = wake_cnt;
    repeat (600) @(posedge clk_sys);
    rd(COUNT_ADDR); chk(rd_d, 32'h55);
    chk(wake_cnt, w0);
  endtask

  task automatic t_irq();
    wr(MODE_ADDR, 32'h00); wr(MASK_ADDR, 32'h0); rd(STAT_ADDR);
    wr(COUNT_ADDR, 32'hfe); wr(MODE_ADDR, 32'hf0); wait_wake();
    wr(MODE_ADDR, 32'h00); chk(irq, 1'b0);
    wr(MASK_ADDR, 32'h1); chk(irq, 1'b1);
    rd(STAT_ADDR); chk(rd_d, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    rd(STAT_ADDR); chk(rd_d, 32'h0);
  endtask

  task automatic t_rtc();
    wr(COUNT_ADDR, 32'h00); wr(MODE_ADDR, 32'h01); wr(COUNT_ADDR, 32'h80);
    rd(COUNT_ADDR); chk(rd_d, 32'h00);
    wr(MODE_ADDR, 32'hf1); w0 = wake_cnt;
    rtc_pulses(RTC_TICKS - 1); rd(COUNT_ADDR); chk(rd_d, 32'hff);
    chk(wake_cnt, w0);
    rtc_pulses(1);
    // one more edge so the pulse counter has taken the wake pulse
    @(posedge clk_sys);
    chk(wake_cnt, w0 + 1);
    rd(COUNT_ADDR); chk(rd_d, 32'h00);
  endtask

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 0;
    repeat (2) @(posedge clk_sys);
    t_regs();
    for (int r = 7; r >= 0; r--) t_rate(r);
    t_hold();
    t_irq();
    t_rtc();
    end_of_test();
  end
endmodule // bt_timer_tb_top

`default_nettype wire
